// File: include/uct_pkg.sv
// Overview of operation
// R1: Transmit-empty enable gates buffer-empty interrupt request
// R2: Transmit-done enable gates done-flag interrupt request
// R3: Receive-full enable gates buffer-full interrupt request
// R4: Line-quiet enable gates idle-flag interrupt request
// R5: Transmitter runs only while transmit enable set
// R6: Transmit enable claims the serial output pin
// R7: Single-wire direction bit steers the shared pin
// R8: Transmit enable off-then-on queues one idle character
// R9: Pin held until pending data, idle, break finish
// R10: Receiver runs only with receive enable; pin released
// R11: Loopback leaves receive pin general purpose
// R12: Writing standby parks receiver awaiting wakeup
// R13: Wake method: idle line or data msb set
// R14: Wakeup condition clears standby bit in hardware
// R15: Writing break one then zero queues one break
// R16: Break is 10/11 zeros, 13/14 when long
// R17: Breaks keep queuing while break bit stays set
// R18: Control register accessible at any time
// R19: Nine-bit select adds ninth data bit
// R20: Single-wire joins output pin to transmitter and receiver
// R21: Enabled requests combine onto one interrupt line
`default_nettype none
package uct_pkg;
  localparam int unsigned ADDR_W = 2;
  typedef logic [ADDR_W-1:0] uct_addr_t;
  typedef logic [7:0] uct_byte_t;

  localparam uct_addr_t CTRL2_OFS = 2'h0;
  localparam uct_addr_t CONFIG_OFS = 2'h1;
  localparam uct_addr_t STATUS_OFS = 2'h2;
  localparam uct_addr_t DATA_OFS = 2'h3;

  // serial_control_two fields
  localparam int unsigned TXE_IRQ_BIT = 7;
  localparam int unsigned TXD_IRQ_BIT = 6;
  localparam int unsigned RXF_IRQ_BIT = 5;
  localparam int unsigned QUIET_IRQ_BIT = 4;
  localparam int unsigned TX_ON_BIT = 3;
  localparam int unsigned RX_ON_BIT = 2;
  localparam int unsigned STANDBY_BIT = 1;
  localparam int unsigned BRK_BIT = 0;

  // Line configuration fields
  localparam int unsigned LOOP_BIT = 7;
  localparam int unsigned TX_NINTH_BIT = 6;
  localparam int unsigned RX_SRC_BIT = 5;
  localparam int unsigned NINE_BIT = 4;
  localparam int unsigned WAKE_BIT = 3;
  localparam int unsigned LONG_BRK_BIT = 2;
  localparam int unsigned SW_DIR_BIT = 1;

  localparam uct_byte_t CTRL2_RST = 8'h00;
  localparam uct_byte_t CONFIG_RST = 8'h00;

  // Bit period stands in for the baud generator, which is not in this block
  localparam int unsigned BIT_CYCLES = 16;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF_LAST = 12'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0] FRAME_BITS8 = 4'ha;
  localparam logic [3:0] FRAME_BITS9 = 4'hb;
  localparam logic [3:0] BRK_EXTRA = 4'h3;
  localparam logic [3:0] RX_BITS8 = 4'h9;
  localparam logic [3:0] RX_BITS9 = 4'ha;
  localparam logic [11:0] IDLE8_CYCLES = 12'(10 * BIT_CYCLES);
  localparam logic [11:0] IDLE9_CYCLES = 12'(11 * BIT_CYCLES);

  typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_PREAMBLE, TX_BREAK} uct_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} uct_rx_e;

  typedef struct packed {
    uct_addr_t addr;
    uct_byte_t wdata;
    logic we;
    logic re;
  } uct_bus_s;

  typedef struct packed {
    uct_byte_t ctrl;
    uct_byte_t cfg;
    uct_byte_t rdata;
    uct_tx_e tx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_bits;
    logic [11:0] tx_cnt;
    logic [8:0] tx_buf;
    logic tx_empty;
    logic tx_done;
    logic idle_pend;
    logic brk_pend;
    logic tx_own;
    logic txd;
    logic tx_oe;
    uct_rx_e rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_bits;
    logic [11:0] rx_cnt;
    logic [8:0] rx_data;
    logic rx_full;
    logic idle_flag;
    logic idle_armed;
    logic [11:0] idle_cnt;
    logic rx_prev;
    logic rx_own;
    logic irq;
  } uct_state_s;
endpackage : uct_pkg
`default_nettype wire

// File: hw/uct_top.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uct_top (
  input wire logic clk,
  input wire logic rstn,
  input wire uct_pkg::uct_bus_s bus,
  output logic [7:0] rdata,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  input wire logic rx_pin_i,
  output logic tx_pin_owned,
  output logic rx_pin_owned,
  output logic irq
);

  uct_pkg::uct_state_s s;
  uct_pkg::uct_state_s n;

  logic ctrl_wr;
  logic cfg_wr;
  logic data_wr;
  logic data_rd;
  logic single_wire;
  logic loop_int;
  logic rx_in;
  logic nine;
  logic [3:0] frame_bits;
  logic [11:0] idle_target;
  logic idle_hit;

  function automatic logic reg_hit(
    input uct_pkg::uct_bus_s b,
    input uct_pkg::uct_addr_t ofs,
    input logic wr
  );
    reg_hit = (wr ? b.we : b.re) && (b.addr == ofs);
  endfunction : reg_hit

  assign ctrl_wr = reg_hit(bus, uct_pkg::CTRL2_OFS, 1'b1);
  assign cfg_wr = reg_hit(bus, uct_pkg::CONFIG_OFS, 1'b1);
  assign data_wr = reg_hit(bus, uct_pkg::DATA_OFS, 1'b1);
  assign data_rd = reg_hit(bus, uct_pkg::DATA_OFS, 1'b0);

  assign nine = s.cfg[uct_pkg::NINE_BIT];
  assign frame_bits = nine ? uct_pkg::FRAME_BITS9 : uct_pkg::FRAME_BITS8; // R19
  assign idle_target = nine ? uct_pkg::IDLE9_CYCLES : uct_pkg::IDLE8_CYCLES;

  assign single_wire = s.cfg[uct_pkg::LOOP_BIT] & s.cfg[uct_pkg::RX_SRC_BIT];
  assign loop_int = s.cfg[uct_pkg::LOOP_BIT] & ~s.cfg[uct_pkg::RX_SRC_BIT];

  // Receiver source: own output in loopback and in single-wire output direction, shared pin in single-wire input direction
  always_comb begin
    if (loop_int) begin
      rx_in = s.txd;
    end else if (single_wire) begin
      rx_in = s.cfg[uct_pkg::SW_DIR_BIT] ? s.txd : tx_pin_i; // R20
    end else begin
      rx_in = rx_pin_i;
    end
  end

  assign idle_hit = s.ctrl[uct_pkg::RX_ON_BIT] &&
                    (s.rx_st == uct_pkg::RX_IDLE) && rx_in &&
                    (s.idle_cnt == idle_target - 12'h001);

  always_comb begin
    n = s;
    n.rdata = 8'h00;

    // Register reads; data only stands in the cycle after the strobe
    if (bus.re) begin
      unique case (bus.addr)
        uct_pkg::CTRL2_OFS: n.rdata = s.ctrl; // R18
        uct_pkg::CONFIG_OFS: n.rdata = s.cfg;
        uct_pkg::STATUS_OFS: n.rdata = {s.tx_empty, s.tx_done, s.rx_full,
                                        s.idle_flag, s.tx_own, 2'b00,
                                        s.rx_data[8]};
        uct_pkg::DATA_OFS: n.rdata = s.rx_data[7:0];
      endcase
    end
    // Clears come first so that a same-cycle set below wins
    if (data_rd) begin
      n.rx_full = 1'b0;
      n.idle_flag = 1'b0;
    end

    // Transmitter
    unique case (s.tx_st)
      uct_pkg::TX_IDLE: begin
        n.tx_cnt = uct_pkg::BIT_LAST;
        if (s.tx_own) begin // R9
          if (s.brk_pend || (s.ctrl[uct_pkg::BRK_BIT] &&
                             s.ctrl[uct_pkg::TX_ON_BIT])) begin // R17
            n.tx_st = uct_pkg::TX_BREAK;
            n.tx_sh = 12'h000;
            n.tx_bits = frame_bits + (s.cfg[uct_pkg::LONG_BRK_BIT] ?
                        uct_pkg::BRK_EXTRA : 4'h0); // R16
            n.brk_pend = 1'b0;
          end else if (s.idle_pend) begin // R8
            n.tx_st = uct_pkg::TX_PREAMBLE;
            n.tx_sh = 12'hfff;
            n.tx_bits = frame_bits;
            n.idle_pend = 1'b0;
          end else if (!s.tx_empty) begin
            n.tx_st = uct_pkg::TX_FRAME;
            // Stop, optional ninth bit, data lsb first, start
            n.tx_sh = {2'b11, nine ? s.tx_buf[8] : 1'b1,
                       s.tx_buf[7:0], 1'b0}; // R19
            n.tx_bits = frame_bits;
            n.tx_empty = 1'b1;
          end
        end
      end
      uct_pkg::TX_FRAME, uct_pkg::TX_PREAMBLE, uct_pkg::TX_BREAK: begin
        if (s.tx_cnt == 12'h000) begin
          n.tx_cnt = uct_pkg::BIT_LAST;
          if (s.tx_bits == 4'h1) begin
            n.tx_st = uct_pkg::TX_IDLE;
          end else begin
            n.tx_bits = s.tx_bits - 4'h1;
            n.tx_sh = {s.tx_st != uct_pkg::TX_BREAK, s.tx_sh[11:1]};
          end
        end else begin
          n.tx_cnt = s.tx_cnt - 12'h001;
        end
      end
    endcase

    // Receiver
    n.rx_prev = rx_in;
    if (!s.ctrl[uct_pkg::RX_ON_BIT]) begin
      n.rx_st = uct_pkg::RX_IDLE; // R10
      n.idle_cnt = 12'h000;
    end else begin
      unique case (s.rx_st)
        uct_pkg::RX_IDLE: begin
          if (s.rx_prev && !rx_in) begin
            n.rx_st = uct_pkg::RX_START;
            n.rx_cnt = uct_pkg::HALF_LAST;
          end
        end
        uct_pkg::RX_START: begin
          // Mid-bit recheck rejects glitches shorter than half a bit
          if (s.rx_cnt == 12'h000) begin
            if (!rx_in) begin
              n.rx_st = uct_pkg::RX_DATA;
              n.rx_cnt = uct_pkg::BIT_LAST;
              n.rx_bits = nine ? uct_pkg::RX_BITS9 : uct_pkg::RX_BITS8;
              n.rx_sh = 10'h000;
            end else begin
              n.rx_st = uct_pkg::RX_IDLE;
            end
          end else begin
            n.rx_cnt = s.rx_cnt - 12'h001;
          end
        end
        uct_pkg::RX_DATA: begin
          if (s.rx_cnt == 12'h000) begin
            n.rx_cnt = uct_pkg::BIT_LAST;
            n.rx_sh = {rx_in, s.rx_sh[9:1]};
            if (s.rx_bits == 4'h1) begin
              n.rx_st = uct_pkg::RX_IDLE;
              // Address mark sits in sh[8] for both character lengths
              if (!s.ctrl[uct_pkg::STANDBY_BIT] ||
                  (s.cfg[uct_pkg::WAKE_BIT] && n.rx_sh[8])) begin // R13
                n.ctrl[uct_pkg::STANDBY_BIT] = 1'b0; // R14
                n.rx_data = nine ? n.rx_sh[8:0] : {1'b0, n.rx_sh[8:1]};
                n.rx_full = 1'b1;
                n.idle_armed = 1'b1;
              end
            end else begin
              n.rx_bits = s.rx_bits - 4'h1;
            end
          end else begin
            n.rx_cnt = s.rx_cnt - 12'h001;
          end
        end
        default: n.rx_st = uct_pkg::RX_IDLE;
      endcase
      // Quiet time counts from the stop bit onward
      if ((s.rx_st == uct_pkg::RX_IDLE) && rx_in) begin
        if (s.idle_cnt != idle_target) begin
          n.idle_cnt = s.idle_cnt + 12'h001;
        end
      end else begin
        n.idle_cnt = 12'h000;
      end
      if (idle_hit) begin
        if (s.ctrl[uct_pkg::STANDBY_BIT] && !s.cfg[uct_pkg::WAKE_BIT]) begin
          n.ctrl[uct_pkg::STANDBY_BIT] = 1'b0; // R13 R14
        end else if (s.idle_armed && !s.ctrl[uct_pkg::STANDBY_BIT]) begin
          // One flag per quiet period; re-armed only by a new character
          n.idle_flag = 1'b1;
          n.idle_armed = 1'b0;
        end
      end
    end

    // Pin ownership lingers until queued work is drained
    n.tx_own = s.ctrl[uct_pkg::TX_ON_BIT] | // R5 R6
               (s.tx_st != uct_pkg::TX_IDLE) |
               (s.tx_own & (s.brk_pend | s.idle_pend | ~s.tx_empty)); // R9

    // Register writes last; they may happen in any transfer state
    if (ctrl_wr) begin
      n.ctrl = bus.wdata; // R18 R12
      if (bus.wdata[uct_pkg::TX_ON_BIT] && !s.ctrl[uct_pkg::TX_ON_BIT]) begin
        n.idle_pend = 1'b1; // R8
      end
      if (bus.wdata[uct_pkg::BRK_BIT]) begin
        n.brk_pend = 1'b1; // R15
      end
    end
    if (cfg_wr) begin
      n.cfg = bus.wdata;
    end
    if (data_wr) begin
      // Ninth bit is taken from config at the moment data is written
      n.tx_buf = {s.cfg[uct_pkg::TX_NINTH_BIT], bus.wdata};
      n.tx_empty = 1'b0;
    end

    n.tx_done = n.tx_empty && (n.tx_st == uct_pkg::TX_IDLE) &&
                !n.brk_pend && !n.idle_pend;
    n.txd = (n.tx_st == uct_pkg::TX_IDLE) ? 1'b1 : n.tx_sh[0];
    n.tx_oe = n.tx_own && !(n.cfg[uct_pkg::LOOP_BIT] &&
              n.cfg[uct_pkg::RX_SRC_BIT] &&
              !n.cfg[uct_pkg::SW_DIR_BIT]); // R6 R7
    n.rx_own = n.ctrl[uct_pkg::RX_ON_BIT] && !n.cfg[uct_pkg::LOOP_BIT]; // R11
    n.irq = (n.ctrl[uct_pkg::TXE_IRQ_BIT] & n.tx_empty) | // R1 R21
            (n.ctrl[uct_pkg::TXD_IRQ_BIT] & n.tx_done) | // R2
            (n.ctrl[uct_pkg::RXF_IRQ_BIT] & n.rx_full) | // R3
            (n.ctrl[uct_pkg::QUIET_IRQ_BIT] & n.idle_flag); // R4
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.ctrl <= uct_pkg::CTRL2_RST;
      s.cfg <= uct_pkg::CONFIG_RST;
      s.tx_empty <= 1'b1;
      s.tx_done <= 1'b1;
      s.txd <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign tx_pin_o = s.txd;
  assign tx_pin_oe = s.tx_oe;
  assign tx_pin_owned = s.tx_own;
  assign rx_pin_owned = s.rx_own;
  assign irq = s.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_brk_wr;
    ctrl_wr && bus.wdata[uct_pkg::BRK_BIT];
  endsequence

  sequence s_tx_ready;
    (s.tx_st == uct_pkg::TX_IDLE) && s.tx_own;
  endsequence

  sequence s_tx_rise;
    ctrl_wr && bus.wdata[uct_pkg::TX_ON_BIT] && !s.ctrl[uct_pkg::TX_ON_BIT];
  endsequence

  sequence s_brk_held;
    s.ctrl[uct_pkg::BRK_BIT] && s.ctrl[uct_pkg::TX_ON_BIT] &&
      (s.tx_st == uct_pkg::TX_IDLE) && s.tx_own;
  endsequence

  sequence s_rx_last;
    (s.rx_st == uct_pkg::RX_DATA) && (s.rx_cnt == 12'h000) &&
      (s.rx_bits == 4'h1);
  endsequence

  sequence s_tx_drained;
    (s.tx_st == uct_pkg::TX_IDLE) && !s.brk_pend && !s.idle_pend &&
      s.tx_empty;
  endsequence

  AST_TXE_IRQ: assert property ( // R1
    s.ctrl[uct_pkg::TXE_IRQ_BIT] && s.tx_empty |-> irq)
    else $error("Transmit-empty request missing");

  AST_TXD_IRQ: assert property ( // R2
    s.ctrl[uct_pkg::TXD_IRQ_BIT] && s.tx_done |-> irq)
    else $error("Transmit-done request missing");

  AST_RXF_IRQ: assert property ( // R3
    s.ctrl[uct_pkg::RXF_IRQ_BIT] && s.rx_full |-> irq)
    else $error("Receive-full request missing");

  AST_QUIET_IRQ: assert property ( // R4
    s.ctrl[uct_pkg::QUIET_IRQ_BIT] && s.idle_flag |-> irq)
    else $error("Line-quiet request missing");

  AST_IRQ_NONE: assert property ( // R21
    !((s.ctrl[uct_pkg::TXE_IRQ_BIT] & s.tx_empty) |
      (s.ctrl[uct_pkg::TXD_IRQ_BIT] & s.tx_done) |
      (s.ctrl[uct_pkg::RXF_IRQ_BIT] & s.rx_full) |
      (s.ctrl[uct_pkg::QUIET_IRQ_BIT] & s.idle_flag)) |-> !irq)
    else $error("Interrupt without enabled flag");

  AST_TX_CLAIM: assert property ( // R6
    s.ctrl[uct_pkg::TX_ON_BIT] |=> tx_pin_owned)
    else $error("Transmit pin not claimed");

  AST_TX_HOLD: assert property ( // R9
    s.tx_st != uct_pkg::TX_IDLE |-> tx_pin_owned ##1 tx_pin_owned)
    else $error("Transmit pin released while shifting");

  AST_TX_OFF: assert property ( // R5
    (s.tx_st == uct_pkg::TX_IDLE) && !s.tx_own |=>
      s.tx_st == uct_pkg::TX_IDLE)
    else $error("Transmitter started while off");

  AST_IDLE_QUEUE: assert property ( // R8
    s_tx_rise |=> s.idle_pend)
    else $error("Idle character not queued");

  AST_BREAK_QUEUE: assert property ( // R15
    s_brk_wr ##1 s_tx_ready |=> s.tx_st == uct_pkg::TX_BREAK)
    else $error("Break not started");

  AST_RX_OFF: assert property ( // R10
    !s.ctrl[uct_pkg::RX_ON_BIT] && !ctrl_wr |=>
      (s.rx_st == uct_pkg::RX_IDLE) [*2])
    else $error("Receiver active while off");

  AST_RX_PIN: assert property ( // R11
    s.cfg[uct_pkg::LOOP_BIT] && !cfg_wr |=> !rx_pin_owned)
    else $error("Receive pin claimed in loopback");

  AST_RX_GPIO: assert property ( // R10
    !s.ctrl[uct_pkg::RX_ON_BIT] && !ctrl_wr |=> !rx_pin_owned)
    else $error("Receive pin held while receiver off");

  AST_BRK_REPEAT: assert property ( // R17
    s_brk_held |=> s.tx_st == uct_pkg::TX_BREAK)
    else $error("Held break bit queued no further break");

  AST_BRK_LOW: assert property ( // R16
    s.tx_st == uct_pkg::TX_BREAK |-> !tx_pin_o)
    else $error("Break character not at logic zero");

  AST_STANDBY_HOLD: assert property ( // R12 R13
    s_rx_last ##0 (s.ctrl[uct_pkg::STANDBY_BIT] &&
      !s.cfg[uct_pkg::WAKE_BIT] && !ctrl_wr) |=>
      s.ctrl[uct_pkg::STANDBY_BIT])
    else $error("Character woke receiver in idle-line method");

  AST_IDLE_WAKE: assert property ( // R14
    idle_hit && s.ctrl[uct_pkg::STANDBY_BIT] &&
      !s.cfg[uct_pkg::WAKE_BIT] && !ctrl_wr |=>
      !s.ctrl[uct_pkg::STANDBY_BIT])
    else $error("Quiet line did not end standby");

  AST_SW_DIR: assert property ( // R7
    single_wire && !s.cfg[uct_pkg::SW_DIR_BIT] && !cfg_wr |=> !tx_pin_oe)
    else $error("Shared pin driven while set as input");

  AST_TX_DRIVE: assert property ( // R6
    tx_pin_owned && !s.cfg[uct_pkg::LOOP_BIT] |-> tx_pin_oe)
    else $error("Owned transmit pin not driven");

  AST_PIN_FREE: assert property ( // R9
    s_tx_drained ##0 !s.ctrl[uct_pkg::TX_ON_BIT] |=> !tx_pin_owned)
    else $error("Transmit pin kept after work drained");

  AST_CTRL_WRITE: assert property ( // R18
    ctrl_wr |=> s.ctrl == $past(bus.wdata))
    else $error("Control write not taken");

  AST_CTRL_READ: assert property ( // R18
    bus.re && (bus.addr == uct_pkg::CTRL2_OFS) |=> rdata == $past(s.ctrl))
    else $error("Control read returned wrong value");

endmodule : uct_top
`default_nettype wire

// File: tb/uct_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module uct_link_partner (
  input wire logic clk,
  input wire logic line_i,
  output logic line_o
);
  logic [7:0] got = 8'h00;
  int unsigned n_got = 0;
  int unsigned lo = 0;
  int unsigned hi = 0;
  int unsigned low_len = 0;
  int unsigned gap = 0;

  initial line_o = 1'b1;

  // Falling-edge sampling keeps clear of the device's own updates
  always @(negedge clk) begin
    if (line_i === 1'b0) begin
      lo <= lo + 1;
      hi <= 0;
    end else begin
      hi <= hi + 1;
      if (lo != 0) begin
        low_len <= lo;
      end
      lo <= 0;
    end
  end

  // A break character decodes as a zero byte
  initial begin
    forever begin
      @(negedge clk);
      if (line_i === 1'b0) begin
        gap = hi;
        repeat (uct_pkg::BIT_CYCLES / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (uct_pkg::BIT_CYCLES) @(negedge clk);
          got[i] = line_i;
        end
        repeat (uct_pkg::BIT_CYCLES) @(negedge clk);
        n_got++;
        wait (line_i === 1'b1);
      end
    end
  end

  task automatic send(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (uct_pkg::BIT_CYCLES) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (uct_pkg::BIT_CYCLES) @(posedge clk);
    end
    line_o <= 1'b1;
    repeat (uct_pkg::BIT_CYCLES) @(posedge clk);
  endtask : send
endmodule : uct_link_partner
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam logic [7:0] TXON = 8'(1 << uct_pkg::TX_ON_BIT);
  localparam logic [7:0] RXON = 8'(1 << uct_pkg::RX_ON_BIT);
  localparam logic [7:0] BRK = 8'(1 << uct_pkg::BRK_BIT);
  localparam logic [7:0] STBY = 8'(1 << uct_pkg::STANDBY_BIT);
  localparam logic [7:0] RXF = 8'(1 << uct_pkg::RXF_IRQ_BIT);
  localparam logic [7:0] QUIET = 8'(1 << uct_pkg::QUIET_IRQ_BIT);
  localparam logic [7:0] LOOP = 8'(1 << uct_pkg::LOOP_BIT);
  localparam logic [7:0] SRC = 8'(1 << uct_pkg::RX_SRC_BIT);
  localparam logic [7:0] DIR = 8'(1 << uct_pkg::SW_DIR_BIT);
  localparam logic [7:0] WAKE = 8'(1 << uct_pkg::WAKE_BIT);
  localparam logic [7:0] LONG = 8'(1 << uct_pkg::LONG_BRK_BIT);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  uct_pkg::uct_bus_s bus = '0;
  logic [7:0] rdata;
  logic tx_pin_o;
  logic tx_pin_oe;
  logic tx_pin_owned;
  logic rx_pin_owned;
  logic irq;
  logic rx_line;
  wire logic tx_line;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int unsigned n;

  // Pull-up holds the line high whenever the device lets go of it
  assign tx_line = tx_pin_oe ? tx_pin_o : 1'b1;
  always #20 clk = ~clk;

  uct_top dut_u (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .tx_pin_i(tx_line), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
    .rx_pin_i(rx_line), .tx_pin_owned(tx_pin_owned),
    .rx_pin_owned(rx_pin_owned), .irq(irq));
  uct_link_partner peer_u (.clk(clk), .line_i(tx_line), .line_o(rx_line));

  task automatic wr(input uct_pkg::uct_addr_t a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus.we <= 1'b0;
  endtask : wr

  task automatic chk_rd(input uct_pkg::uct_addr_t a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus.re <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : chk_rd

  task automatic wait_got(input int unsigned k);
    for (int i = 0; i < 4000 && peer_u.n_got <= k; i++) @(posedge clk);
    if (peer_u.n_got <= k) fails++;
  endtask : wait_got

  task automatic wait_lvl(input logic l);
    for (int i = 0; i < 4000 && tx_line !== l; i++) @(posedge clk);
    if (tx_line !== l) fails++;
  endtask : wait_lvl

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle

  task results;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Whole run needs some 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_rd(uct_pkg::CTRL2_OFS, uct_pkg::CTRL2_RST);
    chk_rd(uct_pkg::CONFIG_OFS, uct_pkg::CONFIG_RST);
    chk_rd(uct_pkg::STATUS_OFS, 8'hc0);
    `CHK({irq, tx_pin_owned, rx_pin_owned, tx_pin_o}, 4'h1)
    for (int b = 4; b < 8; b++) begin
      wr(uct_pkg::CTRL2_OFS, 8'(1 << b));
      settle(1);
      `CHK(irq, 1'(b >= 6))
    end
    wr(uct_pkg::CTRL2_OFS, 8'h00);
    settle(2);
    `CHK(irq, 1'b0)
    // Off-on toggle in mid-frame queues an idle ahead of the next byte
    wr(uct_pkg::CTRL2_OFS, TXON);
    settle(1);
    `CHK({tx_pin_owned, tx_pin_oe}, 2'h3)
    wr(uct_pkg::DATA_OFS, 8'ha5);
    wait_lvl(1'b0);
    n = peer_u.n_got;
    wr(uct_pkg::CTRL2_OFS, 8'h00);
    settle(1);
    `CHK(tx_pin_owned, 1'b1)
    wr(uct_pkg::CTRL2_OFS, TXON);
    wait_got(n);
    `CHK(peer_u.got, 8'ha5)
    wr(uct_pkg::DATA_OFS, 8'h5a);
    wr(uct_pkg::CTRL2_OFS, 8'h00);
    settle(1);
    `CHK(tx_pin_owned, 1'b1)
    wait_got(n + 1);
    `CHK(peer_u.got, 8'h5a)
    `CHK(peer_u.gap >= 10 * uct_pkg::BIT_CYCLES, 1'b1)
    settle(40);
    `CHK({tx_pin_owned, tx_pin_oe}, 2'h0)
    for (int k = 0; k < 2; k++) begin
      wr(uct_pkg::CONFIG_OFS, k ? LONG : 8'h00);
      wr(uct_pkg::CTRL2_OFS, TXON | BRK);
      wr(uct_pkg::CTRL2_OFS, TXON);
      n = peer_u.n_got;
      wait_got(n);
      wait_lvl(1'b1);
      settle(2);
      `CHK(peer_u.low_len, (k ? 13 : 10) * uct_pkg::BIT_CYCLES)
      settle(400);
      `CHK(peer_u.n_got, n + 1)
    end
    wr(uct_pkg::CONFIG_OFS, 8'h00);
    wr(uct_pkg::CTRL2_OFS, RXON | RXF);
    settle(1);
    `CHK(rx_pin_owned, 1'b1)
    peer_u.send(8'h3c);
    settle(2);
    `CHK(irq, 1'b1)
    chk_rd(uct_pkg::DATA_OFS, 8'h3c);
    settle(1);
    `CHK(irq, 1'b0)
    // Quiet flag rises a full character time after the stop bit
    wr(uct_pkg::CTRL2_OFS, RXON | QUIET);
    settle(170);
    `CHK(irq, 1'b1)
    chk_rd(uct_pkg::DATA_OFS, 8'h3c);
    settle(1);
    `CHK(irq, 1'b0)
    wr(uct_pkg::CONFIG_OFS, WAKE);
    wr(uct_pkg::CTRL2_OFS, RXON | STBY);
    peer_u.send(8'h41);
    chk_rd(uct_pkg::CTRL2_OFS, RXON | STBY);
    peer_u.send(8'h81);
    settle(2);
    chk_rd(uct_pkg::CTRL2_OFS, RXON);
    chk_rd(uct_pkg::DATA_OFS, 8'h81);
    // Idle-line method: a character alone keeps standby, quiet ends it
    wr(uct_pkg::CONFIG_OFS, 8'h00);
    wr(uct_pkg::CTRL2_OFS, RXON | STBY);
    peer_u.send(8'h12);
    chk_rd(uct_pkg::CTRL2_OFS, RXON | STBY);
    settle(170);
    chk_rd(uct_pkg::CTRL2_OFS, RXON);
    wr(uct_pkg::CONFIG_OFS, LOOP);
    settle(1);
    `CHK(rx_pin_owned, 1'b0)
    wr(uct_pkg::CONFIG_OFS, LOOP | SRC);
    wr(uct_pkg::CTRL2_OFS, TXON);
    settle(2);
    `CHK(tx_pin_oe, 1'b0)
    wr(uct_pkg::CONFIG_OFS, LOOP | SRC | DIR);
    settle(2);
    `CHK(tx_pin_oe, 1'b1)
    results();
  end
endmodule : tb
`default_nettype wire
